// [rtl/pmicrp_defines.svh]
// Purpose: constants for the power-management two-wire register port
// Assumes: 50 MHz core clock
// Notes: offsets are register indices on the serial port
`ifndef PMICRP_DEFINES_SVH
`define PMICRP_DEFINES_SVH
`define PMICRP_TARGET_ADDR 7'h1B
`define PMICRP_REG_PGOOD 8'h00
`define PMICRP_REG_OC 8'h01
`define PMICRP_REG_OV 8'h02
`define PMICRP_REG_UV 8'h03
`define PMICRP_REG_CONV_EN 8'h04
`define PMICRP_REG_CH_EN 8'h05
`define PMICRP_REG_VOUT1 8'h07
`define PMICRP_REG_VOUT2 8'h08
`define PMICRP_REG_VOUT3 8'h09
`define PMICRP_REG_VOUT4 8'h0A
`define PMICRP_REG_PHASE 8'h0B
`define PMICRP_REG_BSEQ 8'h0C
`define PMICRP_REG_LSEQ 8'h0D
`define PMICRP_REG_PG1 8'h0E
`define PMICRP_REG_PG2 8'h0F
`define PMICRP_REG_PD_DIS 8'h10
`define PMICRP_REG_TEMP 8'h11
`define PMICRP_REG_EXT0 8'h12
`define PMICRP_REG_EXT1 8'h13
`define PMICRP_REG_REV 8'h14
`define PMICRP_RST_CONV_EN 8'h01
`define PMICRP_RST_CH_EN 8'h1F
`define PMICRP_RST_VOUT1 8'h3C
`define PMICRP_RST_VOUT2 8'h0F
`define PMICRP_RST_VOUT3 8'h3C
`define PMICRP_RST_VOUT4 8'h3C
`define PMICRP_RST_PHASE 8'hE4
`define PMICRP_RST_BSEQ 8'hF9
`define PMICRP_RST_LSEQ 8'h00
`define PMICRP_RST_PG1 8'h04
`define PMICRP_RST_PG2 8'h1A
`define PMICRP_RST_PD_DIS 8'h1F
`define PMICRP_REV_ID 8'h5A
`define PMICRP_CONV_PERIOD 16'd1000
`endif

// [rtl/pmicrp_pkg.sv]
// Purpose: types for the power-management register port
// Assumes: nothing
// Notes: gray-coded serial states
package pmicrp_pkg;
  typedef enum logic [2:0] {
    PMICRP_IDLE = 3'h0,
    PMICRP_ADDR = 3'h1,
    PMICRP_ACK_A = 3'h3,
    PMICRP_RX = 3'h2,
    PMICRP_ACK_W = 3'h6,
    PMICRP_TX = 3'h7,
    PMICRP_ACK_R = 3'h5,
    PMICRP_IGNORE = 3'h4
  } pmicrp_state_e;
endpackage

// [rtl/pmicrp_sync.sv]
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: async active-low reset
// Notes: first stage read only by second
`timescale 1ns/1ps
module pmicrp_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // reset
  input wire logic [WIDTH-1:0] d_i, // async input
  output logic [WIDTH-1:0] q_o // synchronised
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '1;
      q_o <= '1;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// [rtl/pmicrp_top.sv]
// Purpose: two-wire target port onto the power-management register bank
// Assumes: scl/sda oversampled by core_clk_i at 50 MHz
// Notes: converter and regulators are outside; status enters on ports
// Operation
// - target only, never drives clock
// - works at 100k, 400k, 1M clocks
// - answers only address 0x1B
// - data line open drain only
// - start is sda fall, scl high
// - stop is sda rise, scl high
// - bytes shifted msb first
// - acknowledge own address by pulling low
// - not-acknowledge is released line
// - extra write bytes go to next register
// - acked reads continue at next register
// - read starts at written register address
// - converter runs only when enabled
// - converter refreshes all three results
// - each result eight bits, own register
// - buck pull-down when disabled unless masked
// - regulator pull-down when disabled unless masked
// - buck power-good after soft-start done
// - only buck three, four change runtime
// - sticky flags clear by writing one
`timescale 1ns/1ps
`include "pmicrp_defines.svh"
module pmicrp_top (
  input wire logic core_clk_i, // 50 MHz clock
  input wire logic rst_n_i, // async reset, low
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // data drive value, always 0
  output logic sda_oe_o, // high while pulling data low
  input wire logic [3:0] buck_ramp_done_i, // soft-start reached target
  input wire logic [3:0] buck_uv_i, // buck under-voltage event
  input wire logic [3:0] buck_ov_i, // buck over-voltage event
  input wire logic [4:0] oc_i, // over-current event, ldo bit 0
  input wire logic ldo_uv_i, // linear_regulator under-voltage event
  input wire logic ldo_pg_i, // linear_regulator power good
  input wire logic overtemp_i, // over-temperature event
  input wire logic supply_low_i, // input supply below threshold
  input wire logic [7:0] conv_data_i, // general_converter sample
  input wire logic conv_done_i, // general_converter sample valid
  output logic conv_start_o, // pulse: start a conversion
  output logic [1:0] conv_sel_o, // 0 temp, 1 input zero, 2 input one
  output logic [4:0] ch_en_o, // channel enables, ldo bit 0
  output logic force_off_o, // force disable bit
  output logic [4:0] pulldown_o, // pull-down active, ldo bit 0
  output logic [7:0] vout_target_o [4], // buck target codes 1..4
  output logic [4:0] buck_pg_o // power-good status, ldo bit 0
);
  import pmicrp_pkg::*;

  logic rst_a_q, rst_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_a_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_q <= rst_a_q;
    end
  end
  wire rst_n = rst_q;
  logic [1:0] pins_s;
  pmicrp_sync #(.WIDTH(2)) u_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .d_i({scl_i, sda_i}),
    .q_o(pins_s)
  );
  logic scl_q, sda_q;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= pins_s[1];
      sda_q <= pins_s[0];
    end
  end
  wire scl_rise = pins_s[1] & ~scl_q;
  wire scl_fall = ~pins_s[1] & scl_q;
  wire start_ev = pins_s[1] & scl_q & sda_q & ~pins_s[0];
  wire stop_ev = pins_s[1] & scl_q & ~sda_q & pins_s[0];
  pmicrp_state_e state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic rw_q, first_q, drive_q, nack_q;
  logic [7:0] ptr_q;
  logic [7:0] rdata;
  logic wr_stb;
  logic [7:0] wr_data;

  // byte completes on the 8th rising clock edge
  wire byte_done = scl_rise & (bit_q == 4'd7);
  wire [7:0] rx_byte = {shift_q[6:0], pins_s[0]};

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PMICRP_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ptr_q <= 8'h00;
      nack_q <= 1'b0;
    end else if (start_ev) begin
      state_q <= PMICRP_ADDR;
      bit_q <= 4'h0;
    end else if (stop_ev) begin
      state_q <= PMICRP_IDLE;
    end else begin
      case (state_q)
        PMICRP_ADDR: begin
          if (scl_rise) begin
            shift_q <= rx_byte;
            bit_q <= bit_q + 4'h1;
          end
          if (byte_done) begin
            if (rx_byte[7:1] == `PMICRP_TARGET_ADDR) begin
              rw_q <= rx_byte[0];
              state_q <= PMICRP_ACK_A;
            end else begin
              state_q <= PMICRP_IGNORE;
            end
          end
        end
        PMICRP_ACK_A: begin
          if (scl_fall && bit_q == 4'd8) begin
            bit_q <= 4'h9;
          end else if (scl_fall && bit_q == 4'd9) begin
            bit_q <= 4'h0;
            first_q <= ~rw_q;
            shift_q <= rdata;
            state_q <= rw_q ? PMICRP_TX : PMICRP_RX;
          end
        end
        PMICRP_RX: begin
          if (scl_rise) begin
            shift_q <= rx_byte;
            bit_q <= bit_q + 4'h1;
          end
          if (byte_done) begin
            state_q <= PMICRP_ACK_W;
          end
        end
        PMICRP_ACK_W: begin
          if (scl_fall && bit_q == 4'd8) begin
            bit_q <= 4'h9;
            if (first_q) begin
              ptr_q <= shift_q;
              first_q <= 1'b0;
            end else begin
              ptr_q <= ptr_q + 8'h01;
            end
          end else if (scl_fall && bit_q == 4'd9) begin
            bit_q <= 4'h0;
            state_q <= PMICRP_RX;
          end
        end
        PMICRP_TX: begin
          if (scl_fall) begin
            shift_q <= {shift_q[6:0], 1'b1};
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'd7) begin
              state_q <= PMICRP_ACK_R;
            end
          end
        end
        PMICRP_ACK_R: begin
          if (scl_rise) begin
            nack_q <= pins_s[0];
          end
          if (scl_fall) begin
            bit_q <= 4'h0;
            if (nack_q) begin
              state_q <= PMICRP_IGNORE;
            end else begin
              ptr_q <= ptr_q + 8'h01;
              shift_q <= rdata;
              state_q <= PMICRP_TX;
            end
          end
        end
        PMICRP_IGNORE: state_q <= PMICRP_IGNORE;
        default: state_q <= PMICRP_IDLE;
      endcase
    end
  end

  // next read byte comes from ptr+1 while the host acks
  wire [7:0] rd_addr = (state_q == PMICRP_ACK_R) ? ptr_q + 8'h01 : ptr_q;

  assign wr_stb = (state_q == PMICRP_ACK_W) && scl_fall && bit_q == 4'd8 && !first_q;
  assign wr_data = shift_q;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      drive_q <= 1'b0;
    end else if (start_ev || stop_ev) begin
      drive_q <= 1'b0;
    end else if (scl_fall) begin
      drive_q <= 1'b0;
      if ((state_q == PMICRP_ACK_A || state_q == PMICRP_ACK_W) && bit_q == 4'd8) begin
        drive_q <= 1'b1; // ack held for the ninth clock
      end else if (state_q == PMICRP_ACK_A && bit_q == 4'd9 && rw_q) begin
        drive_q <= ~rdata[7];
      end else if (state_q == PMICRP_ACK_R && !nack_q) begin
        drive_q <= ~rdata[7];
      end else if (state_q == PMICRP_TX && bit_q != 4'd7) begin
        drive_q <= ~shift_q[6];
      end
    end
  end
  assign sda_o = 1'b0;
  assign sda_oe_o = drive_q;
  // register bank
  logic [7:0] oc_q, ov_q, uv_q, ch_en_q, pd_q, conv_en_q;
  logic [7:0] vout_q [4];
  logic [7:0] phase_q, bseq_q, lseq_q, pg1_q, pg2_q;
  logic [7:0] res_q [3];
  logic uv_flag_q;
  logic [3:0] pg_q;

  wire [7:0] oc_set = {overtemp_i, 2'b00, oc_i};
  wire [7:0] ov_set = {3'b000, buck_ov_i, 1'b0};
  wire [7:0] uv_set = {3'b000, buck_uv_i, ldo_uv_i};
  wire hit_oc = wr_stb && ptr_q == `PMICRP_REG_OC;
  wire hit_ov = wr_stb && ptr_q == `PMICRP_REG_OV;
  wire hit_uv = wr_stb && ptr_q == `PMICRP_REG_UV;
  wire hit_pg = wr_stb && ptr_q == `PMICRP_REG_PGOOD;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oc_q <= 8'h00;
      ov_q <= 8'h00;
      uv_q <= 8'h00;
      uv_flag_q <= 1'b0;
    end else begin
      // set wins over write-one clear
      oc_q <= (oc_q & ~(hit_oc ? wr_data : 8'h00)) | oc_set;
      ov_q <= (ov_q & ~(hit_ov ? wr_data : 8'h00)) | ov_set;
      uv_q <= (uv_q & ~(hit_uv ? wr_data : 8'h00)) | uv_set;
      uv_flag_q <= (uv_flag_q & ~(hit_pg & wr_data[6])) | supply_low_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      conv_en_q <= `PMICRP_RST_CONV_EN;
      ch_en_q <= `PMICRP_RST_CH_EN;
      pd_q <= `PMICRP_RST_PD_DIS;
      vout_q[0] <= `PMICRP_RST_VOUT1;
      vout_q[1] <= `PMICRP_RST_VOUT2;
      vout_q[2] <= `PMICRP_RST_VOUT3;
      vout_q[3] <= `PMICRP_RST_VOUT4;
      phase_q <= `PMICRP_RST_PHASE;
      bseq_q <= `PMICRP_RST_BSEQ;
      lseq_q <= `PMICRP_RST_LSEQ;
      pg1_q <= `PMICRP_RST_PG1;
      pg2_q <= `PMICRP_RST_PG2;
    end else if (wr_stb) begin
      case (ptr_q)
        `PMICRP_REG_CONV_EN: conv_en_q <= {7'h00, wr_data[0]};
        `PMICRP_REG_CH_EN: ch_en_q <= {2'b00, wr_data[5:0]};
        `PMICRP_REG_PD_DIS: pd_q <= {3'b000, wr_data[4:0]};
        `PMICRP_REG_VOUT3: vout_q[2] <= wr_data;
        `PMICRP_REG_VOUT4: vout_q[3] <= wr_data;
        `PMICRP_REG_PHASE: phase_q <= wr_data;
        `PMICRP_REG_BSEQ: bseq_q <= wr_data;
        `PMICRP_REG_LSEQ: lseq_q <= {6'h00, wr_data[1:0]};
        `PMICRP_REG_PG1: pg1_q <= {3'b000, wr_data[4:0]};
        `PMICRP_REG_PG2: pg2_q <= {3'b000, wr_data[4:0]};
        default: conv_en_q <= conv_en_q;
      endcase
    end
  end
  assign vout_target_o = vout_q; // buck one and two stay fixed
  assign ch_en_o = ch_en_q[4:0];
  assign force_off_o = ch_en_q[5];
  assign pulldown_o = ~ch_en_q[4:0] & ~pd_q[4:0];

  // power good follows ramp completion, cleared by buck under- or over-voltage
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pg_q <= 4'h0;
    end else begin
      pg_q <= buck_ramp_done_i & ch_en_q[4:1] & ~buck_uv_i & ~buck_ov_i;
    end
  end
  assign buck_pg_o = {pg_q, ldo_pg_i};

  // converter sequencer: temp, input zero, input one
  logic [15:0] conv_cnt_q;
  logic [1:0] sel_q;
  logic busy_q, start_q;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_q <= 16'h0000;
      sel_q <= 2'd0;
      busy_q <= 1'b0;
      start_q <= 1'b0;
      res_q[0] <= 8'h00;
      res_q[1] <= 8'h00;
      res_q[2] <= 8'h00;
    end else begin
      start_q <= 1'b0;
      if (!conv_en_q[0]) begin
        busy_q <= 1'b0;
        sel_q <= 2'd0;
        conv_cnt_q <= 16'h0000;
      end else if (!busy_q) begin
        if (conv_cnt_q == `PMICRP_CONV_PERIOD) begin
          conv_cnt_q <= 16'h0000;
          busy_q <= 1'b1;
          start_q <= 1'b1;
        end else begin
          conv_cnt_q <= conv_cnt_q + 16'h0001;
        end
      end else if (conv_done_i) begin
        res_q[sel_q] <= conv_data_i;
        if (sel_q == 2'd2) begin
          sel_q <= 2'd0;
          busy_q <= 1'b0;
        end else begin
          sel_q <= sel_q + 2'd1;
          start_q <= 1'b1;
        end
      end
    end
  end
  assign conv_start_o = start_q;
  assign conv_sel_o = sel_q;

  always_comb begin
    case (rd_addr)
      `PMICRP_REG_PGOOD: rdata = {1'b0, uv_flag_q, supply_low_i, pg_q, ldo_pg_i};
      `PMICRP_REG_OC: rdata = oc_q;
      `PMICRP_REG_OV: rdata = ov_q;
      `PMICRP_REG_UV: rdata = uv_q;
      `PMICRP_REG_CONV_EN: rdata = conv_en_q;
      `PMICRP_REG_CH_EN: rdata = ch_en_q;
      `PMICRP_REG_VOUT1: rdata = vout_q[0];
      `PMICRP_REG_VOUT2: rdata = vout_q[1];
      `PMICRP_REG_VOUT3: rdata = vout_q[2];
      `PMICRP_REG_VOUT4: rdata = vout_q[3];
      `PMICRP_REG_PHASE: rdata = phase_q;
      `PMICRP_REG_BSEQ: rdata = bseq_q;
      `PMICRP_REG_LSEQ: rdata = lseq_q;
      `PMICRP_REG_PG1: rdata = pg1_q;
      `PMICRP_REG_PG2: rdata = pg2_q;
      `PMICRP_REG_PD_DIS: rdata = pd_q;
      `PMICRP_REG_TEMP: rdata = res_q[0];
      `PMICRP_REG_EXT0: rdata = res_q[1];
      `PMICRP_REG_EXT1: rdata = res_q[2];
      `PMICRP_REG_REV: rdata = `PMICRP_REV_ID; // arbitrary value
      default: rdata = 8'h00;
    endcase
  end
endmodule

// [sim/pmicrp_top_chk.sv]
// Purpose: port checker for the two-wire register port
// Assumes: host keeps each scl phase at least 4 core clocks
// Notes: bound into pmicrp_top below
`timescale 1ns/1ps
module pmicrp_top_chk (
  input wire logic core_clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic scl_i, // serial clock
  input wire logic sda_i, // data line
  input wire logic sda_o, // drive value
  input wire logic sda_oe_o, // drive enable
  input wire logic [3:0] buck_ramp_done_i, // ramp done
  input wire logic conv_start_o, // conversion start
  input wire logic [1:0] conv_sel_o, // conversion input
  input wire logic [4:0] ch_en_o, // enables
  input wire logic force_off_o, // force off
  input wire logic [4:0] pulldown_o, // pull-downs
  input wire logic [7:0] vout_target_o [4], // targets
  input wire logic [4:0] buck_pg_o // power good
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_sda_low:
  assert property (sda_o == 1'b0) else $error("data line driven high");
  chk_ack_steady:
  assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
    else $error("data drive moved while clock high");
  chk_drive_rise:
  assert property ($rose(sda_oe_o) |-> !scl_i) else $error("drive began with clock high");
  chk_release_low:
  assert property ($fell(sda_oe_o) |-> !scl_i) else $error("release with clock high");
  chk_start_quiet:
  assert property ($fell(sda_i) && scl_i && $past(scl_i) |-> !sda_oe_o)
    else $error("driving at start");
  chk_stop_quiet:
  assert property ($rose(sda_i) && scl_i && $past(scl_i) |-> !sda_oe_o [*5])
    else $error("driving after stop");
  chk_buck_pd:
  assert property (((pulldown_o[4:1] & ch_en_o[4:1]) == 4'h0) || force_off_o)
    else $error("buck pull-down while enabled");
  chk_ldo_pd:
  assert property (!(pulldown_o[0] && ch_en_o[0]) || force_off_o)
    else $error("regulator pull-down while enabled");
  chk_pg_ramp:
  assert property ((buck_pg_o[4:1] & ~$past(buck_ramp_done_i)) == 4'h0)
    else $error("power good before ramp done");
  chk_fixed_vout:
  assert property ($stable(vout_target_o[0]) && $stable(vout_target_o[1]))
    else $error("fixed buck target moved");
  chk_sel_range:
  assert property (conv_sel_o != 2'h3) else $error("bad converter input");
  cover property ($rose(sda_oe_o));
  cover property (conv_start_o);
  cover property (pulldown_o != 5'h00);
endmodule
bind pmicrp_top pmicrp_top_chk u_chk (.core_clk_i, .rst_n_i, .scl_i, .sda_i, .sda_o,
  .sda_oe_o, .buck_ramp_done_i, .conv_start_o, .conv_sel_o, .ch_en_o, .force_off_o,
  .pulldown_o, .vout_target_o, .buck_pg_o);

// [sim/pmicrp_host_model.sv]
// Purpose: host side of the two-wire link
// Assumes: data line pulled up outside
// Notes: 160 ns serial period, paced by core clock falls
`timescale 1ns/1ps
module pmicrp_host_model (
  input wire logic clk_i, // core clock
  input wire logic sda_i, // resolved data line
  output logic scl_o, // serial clock
  output logic sda_pull_o // high pulls data low
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic qtr();
    repeat (2) @(negedge clk_i);
  endtask
  task automatic start();
    sda_pull_o = 1'b0;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_pull_o = 1'b1;
    qtr();
    scl_o = 1'b0;
    qtr();
  endtask
  task automatic stop();
    sda_pull_o = 1'b1;
    qtr();
    scl_o = 1'b1;
    qtr();
    sda_pull_o = 1'b0;
    qtr();
  endtask
  task automatic clk_bit(input logic b, output logic r);
    sda_pull_o = !b;
    qtr();
    scl_o = 1'b1;
    qtr();
    qtr();
    r = sda_i;
    scl_o = 1'b0;
    qtr();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(!ack, r);
  endtask
endmodule

// [sim/pmicrp_top_tb.sv]
// Purpose: self-checking bench for the two-wire register port
// Assumes: bench stands in for host and converter
// Notes: converter answers one clock after each start
`timescale 1ns/1ps
`include "pmicrp_defines.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module pmicrp_top_tb;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic scl, pull, sda, sda_o, sda_oe, cstart, foff, ok;
  logic [3:0] ramp = 4'h0;
  logic [3:0] ov = 4'h0;
  logic [4:0] oc = 5'h00;
  logic otemp = 1'b0;
  logic pg_ldo = 1'b0;
  logic cdone = 1'b0;
  logic [7:0] cdata = 8'h00;
  logic [1:0] csel;
  logic [4:0] ch_en, pd, pg;
  logic [7:0] vout [4];
  logic [7:0] wq [4];
  logic [7:0] rq [8];
  int n_errors = 0;
  int comparisons = 0;
  int n_start = 0;
  always #10 core_clk_i = ~core_clk_i;
  assign sda = !(pull || sda_oe);
  always @(negedge core_clk_i) begin
    cdone <= cstart;
    cdata <= 8'hA0 + {6'h00, csel};
    if (cstart === 1'b1) n_start++;
  end
  pmicrp_top dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .buck_ramp_done_i(ramp), .buck_uv_i(4'h0),
    .buck_ov_i(ov), .oc_i(oc), .ldo_uv_i(1'b0), .ldo_pg_i(pg_ldo), .overtemp_i(otemp),
    .supply_low_i(1'b0), .conv_data_i(cdata), .conv_done_i(cdone), .conv_start_o(cstart),
    .conv_sel_o(csel), .ch_en_o(ch_en), .force_off_o(foff), .pulldown_o(pd),
    .vout_target_o(vout), .buck_pg_o(pg));
  pmicrp_host_model host (.clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input int n);
    logic a;
    host.start();
    host.put_byte({dev, 1'b0}, ok);
    host.put_byte(ptr, a);
    for (int i = 0; i < n; i++) host.put_byte(wq[i], a);
    host.stop();
  endtask
  task automatic wr1(input logic [7:0] ptr, input logic [7:0] d);
    wq[0] = d;
    wr(`PMICRP_TARGET_ADDR, ptr, 1);
  endtask
  task automatic rd(input logic [7:0] ptr, input int n);
    logic a;
    host.start();
    host.put_byte({`PMICRP_TARGET_ADDR, 1'b0}, a);
    host.put_byte(ptr, a);
    host.start();
    host.put_byte({`PMICRP_TARGET_ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) host.get_byte(i < n - 1, rq[i]);
    host.stop();
  endtask
  task automatic conclude();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_reset_values();
    logic [7:0] ex [8];
    ex = '{8'h01, 8'h1F, 8'h00, 8'h3C, 8'h0F, 8'h3C, 8'h3C, 8'hE4};
    rd(8'h04, 8);
    for (int i = 0; i < 8; i++) `CHK("reset read", ex[i], rq[i]);
  endtask
  task automatic t_power_good();
    ramp = 4'h5;
    repeat (8) @(negedge core_clk_i);
    `CHK("pg port", 5'h0A, pg);
    rd(8'h00, 1);
    `CHK("pg reg", 8'h0A, rq[0]);
  endtask
  task automatic t_burst_write();
    wq = '{8'h55, 8'h66, 8'h11, 8'h22};
    wr(`PMICRP_TARGET_ADDR, 8'h07, 4);
    `CHK("addr ack", 1'b1, ok);
    `CHK("vout1", 8'h3C, vout[0]);
    `CHK("vout2", 8'h0F, vout[1]);
    `CHK("vout3", 8'h11, vout[2]);
    `CHK("vout4", 8'h22, vout[3]);
    rd(8'h09, 2);
    `CHK("rd vout3", 8'h11, rq[0]);
    `CHK("rd vout4", 8'h22, rq[1]);
  endtask
  task automatic t_foreign();
    wq[0] = 8'h77;
    wr(7'h1C, 8'h09, 1);
    `CHK("foreign ack", 1'b0, ok);
    rd(8'h09, 1);
    `CHK("foreign kept", 8'h11, rq[0]);
  endtask
  task automatic t_sticky();
    @(negedge core_clk_i);
    ov = 4'h1;
    oc = 5'h01;
    otemp = 1'b1;
    @(negedge core_clk_i);
    ov = 4'h0;
    oc = 5'h00;
    otemp = 1'b0;
    rd(8'h01, 2);
    `CHK("oc set", 8'h81, rq[0]);
    `CHK("ov set", 8'h02, rq[1]);
    wq = '{8'h81, 8'h02, 8'h00, 8'h00};
    wr(`PMICRP_TARGET_ADDR, 8'h01, 2);
    rd(8'h01, 2);
    `CHK("oc clear", 8'h00, rq[0]);
    `CHK("ov clear", 8'h00, rq[1]);
  endtask
  task automatic t_pulldown();
    wr1(8'h10, 8'h02);
    wr1(8'h05, 8'h00);
    `CHK("ch_en", 5'h00, ch_en);
    `CHK("force off", 1'b0, foff);
    `CHK("buck pd", 4'hE, pd[4:1]);
    `CHK("ldo pd", 1'b1, pd[0]);
  endtask
  task automatic t_converter();
    int k;
    for (k = 0; k < 3000 && n_start < 3; k++) @(negedge core_clk_i);
    if (n_start < 3) begin
      n_errors++;
    end else begin
      repeat (20) @(negedge core_clk_i);
      rd(8'h11, 3);
      `CHK("temp", 8'hA0, rq[0]);
      `CHK("ext0", 8'hA1, rq[1]);
      `CHK("ext1", 8'hA2, rq[2]);
      wr1(8'h04, 8'h00);
      repeat (300) @(negedge core_clk_i);
      k = n_start;
      repeat (2500) @(negedge core_clk_i);
      `CHK("conv off", k, n_start);
    end
  endtask
  initial begin
    repeat (10) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    t_reset_values();
    t_power_good();
    t_burst_write();
    t_foreign();
    t_sticky();
    t_pulldown();
    t_converter();
    conclude();
  end
endmodule
